/* clc_pkg.sv */
/*
 * clc_pkg: constants and carriers for the configurable logic cell.
 * assumes a 32-bit apb slave at word-aligned offsets chosen here.
 */
package clc_pkg;
   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] CLC_OFF_CTRL_LOW   = 8'h00;
   localparam logic [7:0] CLC_OFF_CTRL_HIGH  = 8'h04;
   localparam logic [7:0] CLC_OFF_SRC_SEL    = 8'h08;
   localparam logic [7:0] CLC_OFF_GATE_LOW   = 8'h0c;
   localparam logic [7:0] CLC_OFF_GATE_HIGH  = 8'h10;

   // ------------------------------------------------------------
   // control low field positions
   // ------------------------------------------------------------
   localparam int CLC_BIT_ENABLE    = 15;
   localparam int CLC_BIT_RISE_IRQ  = 11;
   localparam int CLC_BIT_FALL_IRQ  = 10;
   localparam int CLC_BIT_PIN_DRIVE = 7;
   localparam int CLC_BIT_STATUS    = 6;
   localparam int CLC_BIT_OUT_INV   = 5;
   localparam int CLC_MODE_LSB      = 0;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] CLC_RST_CTRL_LOW  = 16'h0000;
   localparam logic [3:0]  CLC_RST_CTRL_HIGH = 4'h0;
   localparam logic [11:0] CLC_RST_SRC_SEL   = 12'h000;
   localparam logic [15:0] CLC_RST_GATE      = 16'h0000;
   localparam logic        CLC_RST_STATE     = 1'b0;

   // writable masks of the low control register
   localparam logic [15:0] CLC_WMASK_CTRL_LOW = 16'h8c27;

   // ------------------------------------------------------------
   // cell function codes
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CLC_FN_AND_OR   = 3'h0,
      CLC_FN_OR_XOR   = 3'h1,
      CLC_FN_AND4     = 3'h2,
      CLC_FN_SR_LATCH = 3'h3,
      CLC_FN_DFF_SR   = 3'h4,
      CLC_FN_DFF2_R   = 3'h5,
      CLC_FN_JK_R     = 3'h6,
      CLC_FN_LATCH_SR = 3'h7
   } clc_fn_t;

   // configuration carrier from registers to the core
   typedef struct packed {
      logic        cell_enable;
      logic        output_invert;
      clc_fn_t     mode;
      logic [3:0]  gate_invert;
      logic [11:0] source_select;
      logic [31:0] gate_select;
   } clc_cfg_t;
endpackage

/* clc_core.sv */
/*
 * clc_core: source muxes, gates and the selectable cell function.
 * assumes sources are synchronous to pclk; state updates on pclk.
 */
`timescale 1ns/1ps
module clc_core (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire clc_pkg::clc_cfg_t cfg,
   input  wire logic [7:0]      sources,
   output logic                 cell_out
);
   import clc_pkg::*;

   logic [3:0] pick;
   logic [7:0] cand;
   logic [3:0] gate;
   logic       state_r;
   logic       state_nxt;
   logic       comb_val;

   // ------------------------------------------------------------
   // input stage
   // ------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         pick[i] = sources[cfg.source_select[3*i +: 3]];
         cand[2*i] = pick[i];
         cand[2*i+1] = ~pick[i];
      end
      for (int g = 0; g < 4; g++)
      begin
         gate[g] = (|(cand & cfg.gate_select[8*g +: 8])) ^ cfg.gate_invert[g];
      end
   end

   // ------------------------------------------------------------
   // cell function
   // ------------------------------------------------------------
   always_comb
   begin
      comb_val  = 1'b0;
      state_nxt = state_r;
      unique case (cfg.mode)
         CLC_FN_AND_OR:   comb_val = (gate[0] & gate[1]) | (gate[2] & gate[3]);
         CLC_FN_OR_XOR:   comb_val = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
         CLC_FN_AND4:     comb_val = &gate;
         // set on gates 1|2, reset on gates 3|4, reset dominant
         CLC_FN_SR_LATCH:
            state_nxt = (gate[2] | gate[3]) ? 1'b0 : ((gate[0] | gate[1]) ? 1'b1 : state_r);
         // gate 2 is d, gate 4 set, gate 3 reset
         CLC_FN_DFF_SR:
            state_nxt = gate[2] ? 1'b0 : (gate[3] ? 1'b1 : gate[1]);
         CLC_FN_DFF2_R:
            state_nxt = gate[2] ? 1'b0 : (gate[1] & gate[3]);
         // gate 2 is j, gate 4 k, gate 3 reset
         CLC_FN_JK_R:
            state_nxt = gate[2] ? 1'b0 : ((gate[1] & ~state_r) | (~gate[3] & state_r));
         // gate 1 is the enable of the latch, gate 2 d
         CLC_FN_LATCH_SR:
            state_nxt = gate[2] ? 1'b0 : (gate[3] ? 1'b1 : (gate[0] ? gate[1] : state_r));
      endcase
      if (!cfg.cell_enable)
      begin
         state_nxt = CLC_RST_STATE;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= CLC_RST_STATE;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   always_comb
   begin
      if (!cfg.cell_enable)
      begin
         cell_out = 1'b0;
      end
      else if (cfg.mode inside {CLC_FN_AND_OR, CLC_FN_OR_XOR, CLC_FN_AND4})
      begin
         cell_out = comb_val ^ cfg.output_invert;
      end
      else
      begin
         cell_out = state_r ^ cfg.output_invert;
      end
   end
endmodule

/* clc_top.sv */
/*
 * clc_top: apb register file around the configurable logic cell.
 * assumes sources are synchronous to pclk; pin drive enable set by hw input.
 */
// Design decisions made here: the APB interface to the registers and the placing of the registers.
// Overview of operation
// - four muxes each pick one of eight sources by source select.
// - each mux gives true and inverted copy, eight gate candidates.
// - each gate ORs the candidates enabled by its gate select byte.
// - high control bits 3..0 invert gates four..one.
// - bit 15 enables the cell; clear holds output at zero.
// - mode 000 and-or, 001 or-xor, 010 four-input and.
// - mode 100 is a one-input d flip-flop with set and reset.
// - mode 101 is a two-input d flip-flop with reset.
// - mode 110 is a jk flip-flop with reset.
// - mode 111 is a transparent latch with set and reset.
// - bit 5 inverts the final cell output.
// - bit 7 drives the cell to its pin; read only, resets zero.
// - bit 11 raises an interrupt on rising cell output.
// - unimplemented control bits read as zero.
`timescale 1ns/1ps
module clc_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  sources,
   input  wire logic        pin_drive_request,
   output logic             cell_pin_out,
   output logic             cell_pin_oe,
   output logic             cell_irq
);
   import clc_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [15:0] ctrl_low_r,  ctrl_low_nxt;
   logic [3:0]  ctrl_high_r, ctrl_high_nxt;
   logic [11:0] src_sel_r,   src_sel_nxt;
   logic [15:0] gate_low_r,  gate_low_nxt;
   logic [15:0] gate_high_r, gate_high_nxt;
   logic        pin_drive_r, pin_drive_nxt;
   logic [31:0] prdata_r,    prdata_nxt;
   logic        pready_r,    pready_nxt;
   logic        pslverr_r,   pslverr_nxt;
   logic        out_prev_r,  out_prev_nxt;
   logic        irq_r,       irq_nxt;
   logic        pin_r,       pin_nxt;
   logic        oe_r,        oe_nxt;
   logic        cell_out;
   logic        wr_go;
   logic        rd_go;
   logic        hit;
   clc_cfg_t    cfg;

   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == CLC_OFF_CTRL_LOW) || (a == CLC_OFF_CTRL_HIGH) || (a == CLC_OFF_SRC_SEL)
                 || (a == CLC_OFF_GATE_LOW) || (a == CLC_OFF_GATE_HIGH);
   endfunction

   assign cfg.cell_enable   = ctrl_low_r[CLC_BIT_ENABLE];
   assign cfg.output_invert = ctrl_low_r[CLC_BIT_OUT_INV];
   assign cfg.mode          = clc_fn_t'(ctrl_low_r[CLC_MODE_LSB +: 3]);
   assign cfg.gate_invert   = ctrl_high_r;
   assign cfg.source_select = src_sel_r;
   assign cfg.gate_select   = {gate_high_r, gate_low_r};

   clc_core u_core (
      .pclk     (pclk),
      .presetn  (presetn),
      .cfg      (cfg),
      .sources  (sources),
      .cell_out (cell_out)
   );

   // ------------------------------------------------------------
   // apb slave: one wait state, answer in the second cycle after setup
   // ------------------------------------------------------------
   assign hit   = addr_hit(paddr);
   // writes land on the edge where the master sees pready, not one earlier
   assign wr_go = psel && penable && pready_r && pwrite;
   assign rd_go = psel && penable && !pready_r && !pwrite;

   always_comb
   begin
      ctrl_low_nxt  = ctrl_low_r;
      ctrl_high_nxt = ctrl_high_r;
      src_sel_nxt   = src_sel_r;
      gate_low_nxt  = gate_low_r;
      gate_high_nxt = gate_high_r;
      prdata_nxt    = prdata_r;
      pready_nxt    = psel && penable && !pready_r;
      pslverr_nxt   = psel && penable && !pready_r && !hit;
      if (wr_go)
      begin
         unique case (paddr)
            // status and pin bits are read only, masked from writes
            CLC_OFF_CTRL_LOW:  ctrl_low_nxt  = pwdata[15:0] & CLC_WMASK_CTRL_LOW;
            CLC_OFF_CTRL_HIGH: ctrl_high_nxt = pwdata[3:0];
            CLC_OFF_SRC_SEL:   src_sel_nxt   = pwdata[11:0];
            CLC_OFF_GATE_LOW:  gate_low_nxt  = pwdata[15:0];
            CLC_OFF_GATE_HIGH: gate_high_nxt = pwdata[15:0];
            default:           ;
         endcase
      end
      if (rd_go)
      begin
         unique case (paddr)
            CLC_OFF_CTRL_LOW:
            begin
               prdata_nxt = {16'h0000, ctrl_low_r};
               prdata_nxt[CLC_BIT_STATUS]    = cell_out;
               prdata_nxt[CLC_BIT_PIN_DRIVE] = pin_drive_r;
            end
            CLC_OFF_CTRL_HIGH: prdata_nxt = {28'h0000000, ctrl_high_r};
            CLC_OFF_SRC_SEL:   prdata_nxt = {20'h00000, src_sel_r};
            CLC_OFF_GATE_LOW:  prdata_nxt = {16'h0000, gate_low_r};
            CLC_OFF_GATE_HIGH: prdata_nxt = {16'h0000, gate_high_r};
            default:           prdata_nxt = 32'h00000000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // cell output, pin and edge interrupt
   // ------------------------------------------------------------
   always_comb
   begin
      pin_drive_nxt = pin_drive_request;
      out_prev_nxt  = cell_out;
      pin_nxt       = cell_out;
      oe_nxt        = pin_drive_r;
      irq_nxt = (ctrl_low_r[CLC_BIT_RISE_IRQ] && cell_out && !out_prev_r)
             || (ctrl_low_r[CLC_BIT_FALL_IRQ] && !cell_out && out_prev_r);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_low_r  <= CLC_RST_CTRL_LOW;
         ctrl_high_r <= CLC_RST_CTRL_HIGH;
         src_sel_r   <= CLC_RST_SRC_SEL;
         gate_low_r  <= CLC_RST_GATE;
         gate_high_r <= CLC_RST_GATE;
         pin_drive_r <= 1'b0;
         prdata_r    <= 32'h00000000;
         pready_r    <= 1'b0;
         pslverr_r   <= 1'b0;
         out_prev_r  <= 1'b0;
         irq_r       <= 1'b0;
         pin_r       <= 1'b0;
         oe_r        <= 1'b0;
      end
      else
      begin
         ctrl_low_r  <= ctrl_low_nxt;
         ctrl_high_r <= ctrl_high_nxt;
         src_sel_r   <= src_sel_nxt;
         gate_low_r  <= gate_low_nxt;
         gate_high_r <= gate_high_nxt;
         pin_drive_r <= pin_drive_nxt;
         prdata_r    <= prdata_nxt;
         pready_r    <= pready_nxt;
         pslverr_r   <= pslverr_nxt;
         out_prev_r  <= out_prev_nxt;
         irq_r       <= irq_nxt;
         pin_r       <= pin_nxt;
         oe_r        <= oe_nxt;
      end
   end

   assign prdata       = prdata_r;
   assign pready       = pready_r;
   assign pslverr      = pslverr_r;
   assign cell_pin_out = pin_r;
   assign cell_pin_oe  = oe_r;
   assign cell_irq     = irq_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_disabled_zero;
      @(posedge pclk) disable iff (!presetn)
      !ctrl_low_r[CLC_BIT_ENABLE] |=> !cell_pin_out;
   endproperty
   a_disabled_zero: assert property (p_disabled_zero) else $error("disabled cell output not zero");

   property p_rise_irq;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_low_r[CLC_BIT_RISE_IRQ] && $rose(cell_out)) |=> cell_irq;
   endproperty
   a_rise_irq: assert property (p_rise_irq) else $error("rising edge gave no interrupt");

   property p_fall_irq;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_low_r[CLC_BIT_FALL_IRQ] && $fell(cell_out)) |=> cell_irq;
   endproperty
   a_fall_irq: assert property (p_fall_irq) else $error("falling edge gave no interrupt");

   property p_irq_single;
      @(posedge pclk) disable iff (!presetn)
      cell_irq |-> !$past(cell_irq) || $changed(out_prev_r);
   endproperty
   a_irq_single: assert property (p_irq_single) else $error("interrupt held without new edge");

   property p_no_irq_masked;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_low_r[11:10] == 2'b00) |=> !cell_irq;
   endproperty
   a_no_irq_masked: assert property (p_no_irq_masked) else $error("interrupt with edges disabled");

   property p_and4;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_low_r[15] && ctrl_low_r[2:0] == 3'h2 && !ctrl_low_r[5] && u_core.gate != 4'hf) |-> !cell_out;
   endproperty
   a_and4: assert property (p_and4) else $error("and4 high with a low gate");

   property p_invert;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_low_r[15] && ctrl_low_r[2:0] == 3'h2 && ctrl_low_r[5] && u_core.gate == 4'hf) |-> !cell_out;
   endproperty
   a_invert: assert property (p_invert) else $error("output invert not applied");

   property p_status_read;
      @(posedge pclk) disable iff (!presetn)
      (rd_go && paddr == CLC_OFF_CTRL_LOW) |=> prdata[6] == $past(cell_out) && prdata[4:3] == 2'b00;
   endproperty
   a_status_read: assert property (p_status_read) else $error("status bit or reserved bits wrong");

   property p_pin_oe;
      @(posedge pclk) disable iff (!presetn)
      pin_drive_r |=> cell_pin_oe;
   endproperty
   a_pin_oe: assert property (p_pin_oe) else $error("pin not driven when enabled");

   property p_oe_off;
      @(posedge pclk) disable iff (!presetn)
      !pin_drive_r |=> !cell_pin_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("pin driven while not enabled");

   property p_and_or;
      @(posedge pclk) disable iff (!presetn)
      (cfg.cell_enable && cfg.mode == CLC_FN_AND_OR && !cfg.output_invert)
      |-> cell_out == ((u_core.gate[0] & u_core.gate[1]) | (u_core.gate[2] & u_core.gate[3]));
   endproperty
   a_and_or: assert property (p_and_or) else $error("and-or output wrong");

   property p_or_xor;
      @(posedge pclk) disable iff (!presetn)
      (cfg.cell_enable && cfg.mode == CLC_FN_OR_XOR && !cfg.output_invert)
      |-> cell_out == ((u_core.gate[0] | u_core.gate[1]) ^ (u_core.gate[2] | u_core.gate[3]));
   endproperty
   a_or_xor: assert property (p_or_xor) else $error("or-xor output wrong");

   property p_sr_set;
      @(posedge pclk) disable iff (!presetn)
      (cfg.cell_enable && cfg.mode == CLC_FN_SR_LATCH && (u_core.gate[0] | u_core.gate[1])
       && !(u_core.gate[2] | u_core.gate[3])) |=> u_core.state_r;
   endproperty
   a_sr_set: assert property (p_sr_set) else $error("set-reset latch not set");

   property p_sr_reset;
      @(posedge pclk) disable iff (!presetn)
      (cfg.cell_enable && cfg.mode == CLC_FN_SR_LATCH && (u_core.gate[2] | u_core.gate[3])) |=> !u_core.state_r;
   endproperty
   a_sr_reset: assert property (p_sr_reset) else $error("set-reset latch not reset");

   property p_dff_sr;
      @(posedge pclk) disable iff (!presetn)
      (cfg.cell_enable && cfg.mode == CLC_FN_DFF_SR && !u_core.gate[2])
      |=> u_core.state_r == $past(u_core.gate[3] | u_core.gate[1]);
   endproperty
   a_dff_sr: assert property (p_dff_sr) else $error("d flip-flop with set wrong");

   property p_dff2;
      @(posedge pclk) disable iff (!presetn)
      (cfg.cell_enable && cfg.mode == CLC_FN_DFF2_R && !u_core.gate[2])
      |=> u_core.state_r == $past(u_core.gate[1] & u_core.gate[3]);
   endproperty
   a_dff2: assert property (p_dff2) else $error("two-input d flip-flop wrong");

   property p_jk_toggle;
      @(posedge pclk) disable iff (!presetn)
      (cfg.cell_enable && cfg.mode == CLC_FN_JK_R && !u_core.gate[2] && u_core.gate[1] && u_core.gate[3])
      |=> u_core.state_r != $past(u_core.state_r);
   endproperty
   a_jk_toggle: assert property (p_jk_toggle) else $error("jk flip-flop did not toggle");

   property p_latch_hold;
      @(posedge pclk) disable iff (!presetn)
      (cfg.cell_enable && cfg.mode == CLC_FN_LATCH_SR && !u_core.gate[0] && !u_core.gate[2] && !u_core.gate[3])
      |=> u_core.state_r == $past(u_core.state_r);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("closed latch changed");

   property p_enable_clears;
      @(posedge pclk) disable iff (!presetn)
      !cfg.cell_enable |=> !u_core.state_r;
   endproperty
   a_enable_clears: assert property (p_enable_clears) else $error("state kept while disabled");

   property p_high_reserved;
      @(posedge pclk) disable iff (!presetn)
      (rd_go && paddr == CLC_OFF_CTRL_HIGH) |=> prdata[31:4] == 28'h0000000;
   endproperty
   a_high_reserved: assert property (p_high_reserved) else $error("high control reserved bits set");
endmodule

/* clc_far_end.sv */
/*
 * clc_far_end: peripheral side of the logic cell, the eight sources
 * and the hardware pin-drive request.
 * assumes the bench hands it new values just after each rising edge.
 */
`timescale 1ns/1ps
module clc_far_end (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [7:0] src_req,
   input  wire logic       drv_req,
   output logic [7:0]      sources,
   output logic            pin_drive_request
);
   // retimed so the sources stay synchronous to pclk, as the cell needs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sources           <= 8'h00;
         pin_drive_request <= 1'b0;
      end
      else
      begin
         sources           <= src_req;
         pin_drive_request <= drv_req;
      end
   end
endmodule

/* clc_top_bench.sv */
/*
 * clc_top_bench: register and random cell tests for clc_top.
 * assumes clc_far_end drives the sources and the pin-drive request.
 */
`timescale 1ns/1ps
module clc_top_bench;
   import clc_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, cell_pin_out, cell_pin_oe, cell_irq;
   logic [7:0]  sources, src_req = 8'h00;
   logic        pin_drive_request, drv_req = 1'b0;
   logic [15:0] sh_lo = 16'h0, sh_gl = 16'h0, sh_gh = 16'h0;
   logic [11:0] sh_sel = 12'h0;
   logic [3:0]  sh_hi = 4'h0;
   logic        ex_st, ex_pin, ex_irq, ex_r1, ex_oe;
   logic [31:0] rdv, d, exp_rd;
   logic        err;
   int          error_cnt = 0;
   int          checks = 0;
   integer      seed;
   logic [7:0]  offs [5] = '{CLC_OFF_CTRL_LOW, CLC_OFF_CTRL_HIGH, CLC_OFF_SRC_SEL, CLC_OFF_GATE_LOW, CLC_OFF_GATE_HIGH};

   always #12.5 pclk = ~pclk;

   clc_top i_clc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sources(sources), .pin_drive_request(pin_drive_request), .cell_pin_out(cell_pin_out),
      .cell_pin_oe(cell_pin_oe), .cell_irq(cell_irq));
   clc_far_end i_clc_far_end (.pclk(pclk), .presetn(presetn), .src_req(src_req), .drv_req(drv_req),
      .sources(sources), .pin_drive_request(pin_drive_request));

   // ----------
   // reference model
   // ----------
   function automatic logic [3:0] gates_f(logic [7:0] s);
      logic [3:0]  g;
      logic [7:0]  c;
      logic [31:0] gs;
      gs = {sh_gh, sh_gl};
      for (int k = 0; k < 4; k++)
      begin
         c[2*k]   = s[sh_sel[3*k +: 3]];
         c[2*k+1] = ~c[2*k];
      end
      for (int i = 0; i < 4; i++)
         g[i] = |(gs[8*i +: 8] & c) ^ sh_hi[i];
      return g;
   endfunction

   function automatic logic seq_f(logic [3:0] g, logic st);
      case (sh_lo[2:0])
         3'h3: return (g[2] | g[3]) ? 1'b0 : (g[0] | g[1] | st);
         3'h4: return g[2] ? 1'b0 : (g[3] | g[1]);
         3'h5: return ~g[2] & g[1] & g[3];
         3'h6: return ~g[2] & ((g[1] & ~st) | (~g[3] & st));
         3'h7: return g[2] ? 1'b0 : (g[3] | (g[0] ? g[1] : st));
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic cell_f(logic [3:0] g, logic st);
      logic v;
      case (sh_lo[2:0])
         3'h0: v = (g[0] & g[1]) | (g[2] & g[3]);
         3'h1: v = (g[0] | g[1]) ^ (g[2] | g[3]);
         3'h2: v = &g;
         default: v = st;
      endcase
      return sh_lo[15] & (v ^ sh_lo[5]);
   endfunction

   function automatic logic [31:0] reg_f(logic [7:0] a);
      case (a)
         CLC_OFF_CTRL_LOW: return {16'h0, sh_lo | {8'h0, ex_r1, cell_f(gates_f(sources), ex_st), 6'h0}};
         CLC_OFF_CTRL_HIGH: return {28'h0, sh_hi};
         CLC_OFF_SRC_SEL: return {20'h0, sh_sel};
         CLC_OFF_GATE_LOW: return {16'h0, sh_gl};
         CLC_OFF_GATE_HIGH: return {16'h0, sh_gh};
         default: return 32'h0;
      endcase
   endfunction

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         {ex_st, ex_pin, ex_irq, ex_r1, ex_oe} <= 5'h00;
      else
      begin
         ex_st   <= sh_lo[15] & seq_f(gates_f(sources), ex_st);
         ex_pin  <= cell_f(gates_f(sources), ex_st);
         // edge seen between the live output and the registered one
         ex_irq  <= (sh_lo[11] & cell_f(gates_f(sources), ex_st) & ~ex_pin)
                  | (sh_lo[10] & ~cell_f(gates_f(sources), ex_st) & ex_pin);
         ex_r1   <= pin_drive_request;
         ex_oe   <= ex_r1;
      end
   end

   // ----------
   // compare, bus and closing tasks
   // ----------
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      cmp32({31'h0, got}, {31'h0, exp});
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dw);
      logic rdy;
      rdy = 1'b0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dw;
      @(posedge pclk);
      penable <= 1'b1;
      // look between edges; expectation taken in the cycle the slave samples
      while (rdy !== 1'b1)
      begin
         @(negedge pclk);
         rdy = pready;
         if (rdy !== 1'b1)
            exp_rd = reg_f(a);
         rdv = prdata;
         err = pslverr;
         @(posedge pclk);
      end
      if (wr)
         case (a)
            CLC_OFF_CTRL_LOW: sh_lo <= dw[15:0] & 16'h8c27;
            CLC_OFF_CTRL_HIGH: sh_hi <= dw[3:0];
            CLC_OFF_SRC_SEL: sh_sel <= dw[11:0];
            CLC_OFF_GATE_LOW: sh_gl <= dw[15:0];
            CLC_OFF_GATE_HIGH: sh_gh <= dw[15:0];
            default: ;
         endcase
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd_chk(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
      cmp32(rdv, exp_rd);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(negedge pclk)
   begin
      if (presetn)
      begin
         cmp1(cell_pin_out, ex_pin);
         cmp1(cell_irq, ex_irq);
         cmp1(cell_pin_oe, ex_oe);
      end
   end

   initial
   begin
      #2000000;
      error_cnt++;
      end_sim;
   end

   // ----------
   // main sequence
   // ----------
   initial
   begin
      seed = 32'hd8c2a60e;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (offs[i])
         rd_chk(offs[i]);
      apb(1'b0, 8'h14, 32'h0);
      cmp32(rdv, 32'h0);
      cmp1(err, 1'b1);
      // enable clear with every other bit set: output stays low
      foreach (offs[i])
         apb(1'b1, offs[i], 32'hffff7fff);
      apb(1'b1, 8'h14, 32'hffffffff);
      repeat (4) @(posedge pclk);
      foreach (offs[i])
         rd_chk(offs[i]);
      $display("register test done");
      for (int t = 0; t < 48; t++)
      begin
         d = $random(seed);
         d[15] = 1'b0;
         d[2:0] = 3'(t % 8);
         apb(1'b1, CLC_OFF_CTRL_LOW, d);
         for (int i = 1; i < 5; i++)
            apb(1'b1, offs[i], $random(seed));
         apb(1'b1, CLC_OFF_CTRL_LOW, d | 32'h8000);
         repeat (24)
         begin
            src_req <= 8'($random(seed));
            drv_req <= 1'($random(seed));
            @(posedge pclk);
         end
         repeat (3) @(posedge pclk);
         foreach (offs[i])
            rd_chk(offs[i]);
         $display("cell test %0d done", t);
      end
      end_sim;
   end
endmodule
